// ---- rtl/ovft_timer.v ----
// Overflow timer: 8-bit modulo counter with prescaler and APB registers
`timescale 1ns/10ps
// How it works
// - Four 8-bit registers: control/status, clock config, count, wrap limit.
// - Flag bit 7 sets when the count wraps from the limit to zero.
// - Flag clears by a status read while set, then writing 0.
// - Flag also clears on counter-clear write or any wrap-limit write.
// - Interrupt output is enable bit 6 and the flag together; reset clears enable.
// - Writing 1 to bit 5 zeroes the count and flag; bit reads 0.
// - Halt bit 4 freezes the count; reset sets it.
// - Status bits 3:0 and clock config bits 7:6 read zero.
// - Source 00 bus clock, 01 fixed clock, 10 tick fall, 11 tick rise.
// - Changing source never clears the count.
// - Prescale code n divides the source by two to the n.
// - Prescale codes above 1000 divide by 256.
// - Changing prescale never clears the count.
// - Reset sets source and prescale fields to zero.
// - Count runs to the limit then wraps; limit zero runs freely.
// - Wrap-limit write zeroes count and flag; reset limit is zero.
// - External tick is synchronised; it must run under a quarter bus rate.
module ovft_timer
(
	// Clock and reset
	input  wire        SYS_CLK,
	input  wire        RST_N,
	// APB slave
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [11:0] PADDR,
	input  wire [31:0] PWDATA,
	output reg  [31:0] PRDATA,
	output wire        PREADY,
	output wire        PSLVERR,
	// Count sources from outside
	input  wire        FIXED_RATE_CLOCK,
	input  wire        EXT_TICK_INPUT,
	// Overflow interrupt
	output reg         OVERFLOW_IRQ
);
`include "ovft_defs.vh"

	// Timer state
	reg  [7:0] count_r;
	reg  [7:0] wrap_limit_r;
	reg  [7:0] presc_r;
	reg        overflow_flag_r;
	reg        overflow_irq_en_r;
	reg        counter_halt_r;
	reg  [1:0] source_select_r;
	reg  [3:0] prescale_select_r;
	reg        clr_armed_r;
	// Synchronisers: first stage feeds only the second
	reg        fix_s1_r;
	reg        fix_s2_r;
	reg        fix_d_r;
	reg        tick_s1_r;
	reg        tick_s2_r;
	reg        tick_d_r;
	reg  [2:0] prime_r;
	// Byte chosen by the read decode
	reg  [7:0] rd_byte;

	// Bus decode
	wire       acc     = PSEL & PENABLE;
	wire       wr      = acc & PWRITE;
	wire       rd      = acc & ~PWRITE;
	wire       hit_sc  = (PADDR == `OVFT_ADDR_CTRL_STATUS);
	wire       hit_cc  = (PADDR == `OVFT_ADDR_CLOCK_CONFIG);
	wire       hit_cnt = (PADDR == `OVFT_ADDR_COUNT);
	wire       hit_wl  = (PADDR == `OVFT_ADDR_WRAP_LIMIT);
	wire       mapped  = hit_sc | hit_cc | hit_cnt | hit_wl;
	wire       wr_sc   = wr & hit_sc;
	wire       wr_cc   = wr & hit_cc;
	wire       wr_wl   = wr & hit_wl;

	// Zero-wait slave; unmapped addresses answer with an error
	assign PREADY  = 1'b1;
	assign PSLVERR = acc & ~mapped;

	// two-flop sync of the tick pin; only the second stage is read
	always @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			tick_s1_r <= 1'b0;
			tick_s2_r <= 1'b0;
			tick_d_r  <= 1'b0;
		end
		else
		begin
			tick_s1_r <= EXT_TICK_INPUT;
			tick_s2_r <= tick_s1_r;
			tick_d_r  <= tick_s2_r;
		end
	end

	// Fixed-rate clock takes the same two-flop path as the tick pin
	always @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			fix_s1_r <= 1'b0;
			fix_s2_r <= 1'b0;
			fix_d_r  <= 1'b0;
		end
		else
		begin
			fix_s1_r <= FIXED_RATE_CLOCK;
			fix_s2_r <= fix_s1_r;
			fix_d_r  <= fix_s2_r;
		end
	end

	// Edge detectors stay blind until sync and delay flops hold real samples
	// A pin idling high would otherwise fake an edge right after reset
	always @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			prime_r <= `OVFT_RST_PRIME;
		else
			prime_r <= {prime_r[1:0], 1'b1};
	end
	wire       prime_ok = prime_r[2];

	// one step per bus clock or per selected edge
	reg src_step;
	always @*
	begin
		case (source_select_r)
			`OVFT_SRC_BUS:      src_step = 1'b1;
			`OVFT_SRC_FIXED:    src_step = fix_s2_r & ~fix_d_r & prime_ok;
			`OVFT_SRC_EXT_FALL: src_step = ~tick_s2_r & tick_d_r & prime_ok;
			default:            src_step = tick_s2_r & ~tick_d_r & prime_ok;
		endcase
	end

	// divide by two to the code
	// codes above the max saturate at 256
	wire [3:0] ps_eff = (prescale_select_r > `OVFT_PS_MAX) ? `OVFT_PS_MAX : prescale_select_r;
	wire [8:0] div_n  = 9'h001 << ps_eff;
	wire [7:0] div_m1 = div_n[7:0] - 8'h01;
	// Prescaler carry; divider steps only on run steps and keeps its phase across changes
	wire       presc_end = (ps_eff == 4'h0) | (presc_r >= div_m1);
	wire       run_step  = ~counter_halt_r & src_step;
	wire       inc       = run_step & presc_end;
	// wrap at limit; limit zero wraps at all-ones
	// A zero limit must not match a zero count, or the counter would stick
	wire       free_run  = (wrap_limit_r == `OVFT_RST_LIMIT);
	wire       at_limit  = free_run ? (count_r == `OVFT_FREE_WRAP) :
	                                  (count_r == wrap_limit_r);
	wire       wrap      = inc & at_limit;
	wire       clr_cmd   = wr_sc & PWDATA[`OVFT_SC_CLEAR_BIT];

	// source and prescale changes never touch the count
	// only clear and limit writes reset it
	always @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			count_r <= `OVFT_RST_COUNT;
			presc_r <= `OVFT_RST_PRESC;
		end
		else
		begin
			// limit write restarts counting from zero
			if (clr_cmd | wr_wl)
			begin
				count_r <= `OVFT_RST_COUNT;
				presc_r <= `OVFT_RST_PRESC;
			end
			else if (run_step)
			begin
				presc_r <= presc_end ? 8'h00 : presc_r + 8'h01;
				if (wrap)
					count_r <= 8'h00;
				else if (inc)
					count_r <= count_r + 8'h01;
			end
		end
	end

	// wrap sets the flag and wins over any clear in the same cycle
	// clear bit or limit write drops the flag
	// armed read then a write of 0 clears
	always @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			overflow_flag_r <= 1'b0;
		else if (wrap)
			overflow_flag_r <= 1'b1;
		else if (clr_cmd | wr_wl)
			overflow_flag_r <= 1'b0;
		else if (wr_sc & clr_armed_r & ~PWDATA[`OVFT_SC_FLAG_BIT])
			overflow_flag_r <= 1'b0;
	end

	// an overflow disarms the pending clear
	// Armed from the byte handed to software, not the live flag, so a wrap
	// landing on the setup edge can never be cleared unseen
	always @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			clr_armed_r <= 1'b0;
		else if (wrap | wr_sc | clr_cmd | wr_wl)
			clr_armed_r <= 1'b0;
		else if (rd & hit_sc & PRDATA[`OVFT_SC_FLAG_BIT])
			clr_armed_r <= 1'b1;
	end

	// halt bit, set by reset so the counter starts stopped
	always @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			overflow_irq_en_r <= `OVFT_RST_IRQEN;
			counter_halt_r    <= `OVFT_RST_HALT;
		end
		else if (wr_sc)
		begin
			overflow_irq_en_r <= PWDATA[`OVFT_SC_IRQEN_BIT];
			counter_halt_r    <= PWDATA[`OVFT_SC_HALT_BIT];
		end
	end

	// reset selects the bus clock with no division
	always @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			source_select_r   <= `OVFT_RST_SRC;
			prescale_select_r <= `OVFT_RST_PS;
		end
		else if (wr_cc)
		begin
			source_select_r   <= PWDATA[`OVFT_CC_SRC_HI:`OVFT_CC_SRC_LO];
			prescale_select_r <= PWDATA[`OVFT_CC_PS_HI:`OVFT_CC_PS_LO];
		end
	end

	always @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			wrap_limit_r <= `OVFT_RST_LIMIT;
		else if (wr_wl)
			wrap_limit_r <= PWDATA[`OVFT_REG_HI:0];
	end

	// registered interrupt, enable gates the flag
	always @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			OVERFLOW_IRQ <= 1'b0;
		else
			OVERFLOW_IRQ <= overflow_flag_r & overflow_irq_en_r;
	end

	// read mux of the four byte registers
	// unused bits and the clear bit read zero
	always @*
	begin
		rd_byte = 8'h00;
		if (hit_sc)
			rd_byte = {overflow_flag_r, overflow_irq_en_r, 1'b0, counter_halt_r, 4'h0};
		else if (hit_cc)
			rd_byte = {2'h0, source_select_r, prescale_select_r};
		else if (hit_cnt)
			rd_byte = count_r;
		else if (hit_wl)
			rd_byte = wrap_limit_r;
	end

	// Read data launched at the setup edge, so it stands through the access
	// Trade-off: the word shows the state of the setup cycle, one clock old
	always @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			PRDATA <= `OVFT_RST_RDATA;
		else if (PSEL & ~PENABLE & ~PWRITE)
			PRDATA <= {24'h000000, rd_byte};
	end

endmodule // ovft_timer

// ---- rtl/ovft_defs.vh ----
// Register offsets, field positions and reset values of the overflow timer
`ifndef OVFT_DEFS_VH
`define OVFT_DEFS_VH

// Register byte offsets on the APB word map
`define OVFT_ADDR_CTRL_STATUS  12'h000
`define OVFT_ADDR_CLOCK_CONFIG 12'h004
`define OVFT_ADDR_COUNT        12'h008
`define OVFT_ADDR_WRAP_LIMIT   12'h00c

// Status and control field positions
`define OVFT_SC_FLAG_BIT   7
`define OVFT_SC_IRQEN_BIT  6
`define OVFT_SC_CLEAR_BIT  5
`define OVFT_SC_HALT_BIT   4

// Clock configuration fields
`define OVFT_CC_SRC_HI     5
`define OVFT_CC_SRC_LO     4
`define OVFT_CC_PS_HI      3
`define OVFT_CC_PS_LO      0

// Source select encodings
`define OVFT_SRC_BUS       2'h0
`define OVFT_SRC_FIXED     2'h1
`define OVFT_SRC_EXT_FALL  2'h2
`define OVFT_SRC_EXT_RISE  2'h3

// Largest prescale code; higher codes saturate here
`define OVFT_PS_MAX        4'h8

// Reset values
`define OVFT_RST_COUNT     8'h00
`define OVFT_RST_LIMIT     8'h00
`define OVFT_RST_SRC       2'h0
`define OVFT_RST_PS        4'h0
`define OVFT_RST_PRESC     8'h00
`define OVFT_RST_HALT      1'b1
`define OVFT_RST_IRQEN     1'b0
`define OVFT_RST_PRIME     3'h0
`define OVFT_RST_RDATA     32'h0000_0000

// Free-running mode wraps from all-ones when the limit is zero
`define OVFT_FREE_WRAP     8'hff

// Top bit of each byte-wide register
`define OVFT_REG_HI        7

`endif

// ---- tb/ovft_timer_properties.sv ----
// Port checker of the overflow timer
`timescale 1ns/10ps
module ovft_timer_chk
(
	// Clock and reset
	input wire        SYS_CLK,
	input wire        RST_N,
	// APB slave side
	input wire        PSEL,
	input wire        PENABLE,
	input wire        PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	input wire [31:0] PRDATA,
	input wire        PREADY,
	input wire        PSLVERR,
	// Interrupt
	input wire        OVERFLOW_IRQ
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	// Decodes; read data stands through the access cycle
	wire acc = PSEL && PENABLE;
	wire rd_sc = acc && !PWRITE && PADDR == 12'h000;
	wire rd_cc = acc && !PWRITE && PADDR == 12'h004;
	wire rd_cnt = acc && !PWRITE && PADDR == 12'h008;
	wire wr_lim = acc && PWRITE && PADDR == 12'h00c;
	wire wr_clr = acc && PWRITE && PADDR == 12'h000 && PWDATA[5];
	a_ready_high: assert property (PREADY) else $error("pready low");
	a_sc_zeros: assert property (rd_sc |-> PRDATA[5] == 1'b0 && PRDATA[3:0] == 4'h0)
		else $error("status stray bits");
	a_cc_zeros: assert property (rd_cc |-> PRDATA[7:6] == 2'h0)
		else $error("config stray bits");
	a_irq_follow: assert property (rd_sc |-> OVERFLOW_IRQ == (PRDATA[7] & PRDATA[6]))
		else $error("irq not flag and enable");
	a_lim_count: assert property (wr_lim ##2 rd_cnt |-> PRDATA[7:0] == 8'h00)
		else $error("count kept after limit write");
	a_clr_count: assert property (wr_clr ##2 rd_cnt |-> PRDATA[7:0] == 8'h00)
		else $error("count kept after clear");
	a_lim_flag: assert property (wr_lim ##2 rd_sc && PRDATA[4] |-> !PRDATA[7])
		else $error("flag kept after limit write");
	a_err_map: assert property (acc && PADDR[1:0] == 2'h0 |-> PSLVERR == (PADDR[11:4] != 0))
		else $error("slave error on wrong address");
	// Main scenarios
	cover property (wr_lim);
	cover property (OVERFLOW_IRQ);
	cover property (acc && PSLVERR);
	cover property (wr_clr);
endmodule // ovft_timer_chk

bind ovft_timer ovft_timer_chk ovft_timer_chk_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .OVERFLOW_IRQ(OVERFLOW_IRQ));

// ---- tb/ovft_timer_bench.sv ----
// Self-checking bench of the overflow timer
`timescale 1ns/10ps
module ovft_timer_bench;
	reg         sys_clk = 1'b0;
	reg         rst_n = 1'b0;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [11:0] paddr = 12'h000;
	reg  [31:0] pwdata = 32'h0;
	reg         fix_clk = 1'b0;
	reg         tick = 1'b0;
	wire [31:0] prdata;
	wire        pready, pslverr, irq;
	reg  [31:0] rd;
	reg         perr;
	reg  [7:0]  cfg;
	integer     err_count, checked, i, d;
	always #2 sys_clk = ~sys_clk;
	ovft_timer ovft_timer_i (.SYS_CLK(sys_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .FIXED_RATE_CLOCK(fix_clk), .EXT_TICK_INPUT(tick), .OVERFLOW_IRQ(irq));
	task chk(input [23:0] nm, input [31:0] seen, input [31:0] exp);
	begin
		checked = checked + 1;
		if (seen !== exp)
		begin
			err_count = err_count + 1;
			$display("Error %s exp %h seen %h", nm, exp, seen);
		end
	end
	endtask
	// APB transfer; held until pready is sampled high
	task xfer(input w, input [11:0] a, input [7:0] v);
	begin
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, v};
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
			@(posedge sys_clk);
		rd = prdata;
		perr = pslverr;
	end
	endtask
	task idle(input integer n);
	begin
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (n) @(posedge sys_clk);
	end
	endtask
	task pulses;
	begin
		repeat (6)
		begin
			fix_clk <= ~fix_clk;
			tick <= ~tick;
			repeat (8) @(posedge sys_clk);
		end
	end
	endtask
	task close_out;
	begin
		if (err_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask
	// Hang guard, far past the run length
	initial
	begin
		#100000;
		err_count = err_count + 1;
		close_out;
	end
	initial
	begin
		err_count = 0;
		checked = 0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		xfer(0, 12'h000, 8'h00);
		chk("sc", rd, 32'h10);
		xfer(0, 12'h010, 8'h00);
		chk("err", {31'h0, perr}, 32'h1);
		xfer(1, 12'h004, 8'hff);
		xfer(0, 12'h004, 8'h00);
		chk("cc", rd, 32'h3f);
		xfer(1, 12'h004, 8'h00);
		// Overflow at limit 3, then two-step clear
		xfer(1, 12'h00c, 8'h03);
		xfer(1, 12'h000, 8'h00);
		idle(20);
		// a wrap after the arming read cancels the clear
		xfer(0, 12'h000, 8'h00);
		chk("ovf", {31'h0, rd[7]}, 32'h1);
		idle(4);
		xfer(1, 12'h000, 8'h10);
		xfer(0, 12'h000, 8'h00);
		chk("sc", rd, 32'h90);
		xfer(0, 12'h008, 8'h00);
		chk("cnt", {31'h0, rd[7:0] <= 8'h03}, 32'h1);
		xfer(1, 12'h000, 8'h10);
		xfer(0, 12'h000, 8'h00);
		chk("sc", rd, 32'h10);
		// Enable set with flag clear, as software must
		// flag cleared before enable
		xfer(1, 12'h000, 8'h50);
		xfer(1, 12'h000, 8'h40);
		idle(20);
		xfer(1, 12'h000, 8'h50);
		idle(1);
		chk("irq", {31'h0, irq}, 32'h1);
		xfer(1, 12'h00c, 8'h00);
		xfer(0, 12'h000, 8'h00);
		chk("sc", rd, 32'h50);
		idle(2);
		chk("irq", {31'h0, irq}, 32'h0);
		// Prescale 16, 256 and saturated code on bus clock
		cfg = 8'h04;
		for (i = 0; i < 3; i = i + 1)
		begin
			d = (cfg == 8'h04) ? 16 : 256;
			xfer(1, 12'h004, cfg);
			xfer(1, 12'h000, 8'h20);
			idle(d * 5 + d / 2 - 2);
			xfer(1, 12'h000, 8'h10);
			xfer(1, 12'h004, 8'h11);
			xfer(0, 12'h008, 8'h00);
			chk("cnt", rd, 32'h5);
			xfer(1, 12'h000, 8'h30);
			xfer(0, 12'h008, 8'h00);
			chk("cnt", rd, 32'h0);
			cfg = cfg + 8'h04;
		end
		// Fixed clock and both tick edges, three each
		for (i = 1; i < 4; i = i + 1)
		begin
			xfer(1, 12'h004, {2'b00, i[1:0], 4'h0});
			xfer(1, 12'h000, 8'h20);
			idle(1);
			pulses;
			idle(8);
			xfer(1, 12'h000, 8'h10);
			xfer(0, 12'h008, 8'h00);
			chk("src", rd, 32'h3);
			xfer(1, 12'h00c, 8'h00);
			xfer(0, 12'h008, 8'h00);
			chk("lim", rd, 32'h0);
		end
		idle(1);
		close_out;
	end
endmodule // ovft_timer_bench
